/* logic/mwd_top.sv */
// Wakeup detector: sniff rate register, threshold shadows, axis combine
`timescale 1ns/100ps
`include "mwd_map.svh"
module mwd_top (
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    input  wire logic                  sniff_active,
    input  wire logic                  sample_valid,
    input  wire mwd_pkg::mwd_sample_t  sample_x,
    input  wire mwd_pkg::mwd_sample_t  sample_y,
    input  wire mwd_pkg::mwd_sample_t  sample_z,
    input  wire logic [2:0]            axis_enable,
    output logic [3:0]                 watch_sample_rate_sel,
    output logic [2:0]                 standby_clock_rate_sel,
    output logic                       wake_irq
);
    logic [3:0]            sr_q;
    logic [2:0]            stb_q;
    mwd_pkg::mwd_method_t  method_q;
    mwd_pkg::mwd_comb_t    comb_q;
    logic [2:0]            sel_q;
    mwd_pkg::mwd_field_t   thr_q [`MWD_NUM_AXES];
    mwd_pkg::mwd_field_t   cnt_q [`MWD_NUM_AXES];
    logic [7:0]            rdata_q;
    logic                  irq_q;

    logic                  wr_sniff_w;
    logic                  wr_thr_w;
    logic                  wr_sel_w;
    logic [2:0]            hit_w;
    logic [2:0]            en_hit_w;
    logic                  any_w;
    logic                  all_w;
    logic                  wake_w;
    logic [7:0]            rd_mux_w;
    mwd_pkg::mwd_field_t   shadow_rd_w;
    mwd_pkg::mwd_field_t   part_rd_w [`MWD_NUM_AXES];
    mwd_pkg::mwd_sample_t  samp_w [`MWD_NUM_AXES];

    mwd_axis_if ax [`MWD_NUM_AXES] ();

    assign samp_w[0] = sample_x;
    assign samp_w[1] = sample_y;
    assign samp_w[2] = sample_z;

    // Write decode
    assign wr_sniff_w = reg_wr && (reg_addr == `MWD_ADDR_SNIFF);
    assign wr_thr_w   = reg_wr && (reg_addr == `MWD_ADDR_THR);
    assign wr_sel_w   = reg_wr && (reg_addr == `MWD_ADDR_SEL);

    // Per-axis shadow registers and comparators
    for (genvar i = 0; i < `MWD_NUM_AXES; i++) begin : g_axis
        localparam logic [2:0] THR_CODE = `MWD_SEL_THR_BASE + 3'(i);
        localparam logic [2:0] CNT_CODE = `MWD_SEL_CNT_BASE + 3'(i);
        logic wr_t_w;
        logic wr_c_w;
        assign wr_t_w = wr_thr_w && (sel_q == THR_CODE);
        assign wr_c_w = wr_thr_w && (sel_q == CNT_CODE);
        assign part_rd_w[i] = ((sel_q == THR_CODE) ? thr_q[i] : 6'h00)
                            | ((sel_q == CNT_CODE) ? cnt_q[i] : 6'h00);

        always_ff @(posedge clk) begin
            if (srst) begin
                thr_q[i] <= `MWD_RST_FIELD;
                cnt_q[i] <= `MWD_RST_FIELD;
            end else begin
                if (wr_t_w) begin
                    thr_q[i] <= reg_wdata[`MWD_FIELD_MSB:0];
                end
                if (wr_c_w) begin
                    cnt_q[i] <= reg_wdata[`MWD_FIELD_MSB:0];
                end
            end
        end

        assign ax[i].sample = samp_w[i];
        assign ax[i].valid  = sample_valid;
        assign ax[i].active = sniff_active;
        assign ax[i].method = method_q;
        assign ax[i].thr    = thr_q[i];
        assign ax[i].cnt    = cnt_q[i];
        assign hit_w[i]     = ax[i].hit;

        mwd_axis u_axis (
            .clk  (clk),
            .srst (srst),
            .ax   (ax[i].axis)
        );
    end

    // Shadow read: codes 000 and 100 select nothing
    assign shadow_rd_w = part_rd_w[0] | part_rd_w[1] | part_rd_w[2];

    // Axis combine
    assign en_hit_w = hit_w & axis_enable;
    assign any_w    = |en_hit_w;
    assign all_w    = (|axis_enable) && ((hit_w | ~axis_enable) == 3'h7);
    assign wake_w   = sniff_active
                      && ((comb_q == mwd_pkg::MWD_COMB_AND) ? all_w : any_w);

    // Read mux, reserved and unmapped bits read zero
    assign rd_mux_w = (reg_addr == `MWD_ADDR_SNIFF) ? {stb_q, 1'b0, sr_q} :
                      (reg_addr == `MWD_ADDR_THR)   ? {method_q, comb_q, shadow_rd_w} :
                      (reg_addr == `MWD_ADDR_SEL)   ? {5'h00, sel_q} : 8'h00;

    always_ff @(posedge clk) begin
        if (srst) begin
            sr_q     <= `MWD_RST_SR;
            stb_q    <= `MWD_RST_STB;
            method_q <= mwd_pkg::MWD_CUR_VS_PREV;
            comb_q   <= mwd_pkg::MWD_COMB_OR;
            sel_q    <= `MWD_RST_SEL;
        end else begin
            if (wr_sniff_w) begin
                sr_q  <= reg_wdata[`MWD_SR_MSB:`MWD_SR_LSB];
                stb_q <= reg_wdata[`MWD_STB_MSB:`MWD_STB_LSB];
            end
            if (wr_thr_w) begin
                method_q <= mwd_pkg::mwd_method_t'(reg_wdata[`MWD_MODE_BIT]);
                comb_q   <= mwd_pkg::mwd_comb_t'(reg_wdata[`MWD_ANDOR_BIT]);
            end
            if (wr_sel_w) begin
                sel_q <= reg_wdata[`MWD_SEL_MSB:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= 8'h00;
            irq_q   <= 1'b0;
        end else begin
            if (reg_rd) begin
                rdata_q <= rd_mux_w;
            end
            irq_q <= wake_w;
        end
    end

    assign reg_rdata              = rdata_q;
    assign watch_sample_rate_sel  = sr_q;
    assign standby_clock_rate_sel = stb_q;
    assign wake_irq               = irq_q;

    rate_write_a : assert property (@(posedge clk) disable iff (srst)
        wr_sniff_w |=> (sr_q == $past(reg_wdata[3:0])) && (stb_q == $past(reg_wdata[7:5])))
        else $error("Rate register write not stored");

    irq_or_a : assert property (@(posedge clk) disable iff (srst)
        (comb_q == mwd_pkg::MWD_COMB_OR) && sniff_active && |(hit_w & axis_enable)
        |=> wake_irq)
        else $error("OR combine missed an enabled axis");

    irq_and_a : assert property (@(posedge clk) disable iff (srst)
        (comb_q == mwd_pkg::MWD_COMB_AND) && ((hit_w & axis_enable) != axis_enable)
        |=> !wake_irq)
        else $error("AND combine fired with an axis missing");

    irq_idle_a : assert property (@(posedge clk) disable iff (srst)
        !sniff_active |=> !wake_irq)
        else $error("Wakeup outside sniff");

    shadow_none_a : assert property (@(posedge clk) disable iff (srst)
        reg_rd && (reg_addr == `MWD_ADDR_THR) && (sel_q == 3'h0)
        |=> reg_rdata[5:0] == 6'h00)
        else $error("Select 000 read a shadow value");

    x_thr_write_a : assert property (@(posedge clk) disable iff (srst)
        wr_thr_w && (sel_q == 3'h1) |=> thr_q[0] == $past(reg_wdata[5:0]))
        else $error("X threshold write lost");

    z_cnt_write_a : assert property (@(posedge clk) disable iff (srst)
        wr_thr_w && (sel_q == 3'h7) |=> cnt_q[2] == $past(reg_wdata[5:0]))
        else $error("Z count write lost");

    reset_cfg_a : assert property (@(posedge clk)
        srst |=> (method_q == mwd_pkg::MWD_CUR_VS_PREV) && (comb_q == mwd_pkg::MWD_COMB_OR)
        && (thr_q[0] == 6'h00) && (sr_q == 4'h0))
        else $error("Configuration not zero after reset");

    method_bit_a : assert property (@(posedge clk) disable iff (srst)
        wr_thr_w |=> method_q == mwd_pkg::mwd_method_t'($past(reg_wdata[7])))
        else $error("Delta method bit not stored");

    y_thr_write_a : assert property (@(posedge clk) disable iff (srst)
        wr_thr_w && (sel_q == 3'h2) |=> thr_q[1] == $past(reg_wdata[5:0]))
        else $error("Y threshold write lost");

    shadow_four_a : assert property (@(posedge clk) disable iff (srst)
        reg_rd && (reg_addr == `MWD_ADDR_THR) && (sel_q == 3'h4)
        |=> reg_rdata[5:0] == 6'h00)
        else $error("Select 100 read a shadow value");

    rsvd_read_a : assert property (@(posedge clk) disable iff (srst)
        reg_rd && (reg_addr == `MWD_ADDR_SNIFF) |=> !reg_rdata[4])
        else $error("Reserved rate bit read as one");

    wake_cause_a : assert property (@(posedge clk) disable iff (srst)
        wake_irq |-> $past(sniff_active) && ($past(hit_w & axis_enable) != 3'h0))
        else $error("Wakeup without an enabled axis hit");

    reset_out_a : assert property (@(posedge clk)
        srst |=> !wake_irq && (reg_rdata == 8'h00) && (sel_q == 3'h0))
        else $error("Outputs not cleared by reset");
endmodule : mwd_top

/* logic/mwd_map.svh */
// Register map, field positions and reset values of the wakeup detector
`ifndef MWD_MAP_SVH
`define MWD_MAP_SVH
`define MWD_ADDR_SNIFF    8'h12
`define MWD_ADDR_THR      8'h13
`define MWD_ADDR_SEL      8'h14
`define MWD_SR_LSB        0
`define MWD_SR_MSB        3
`define MWD_RSVD_BIT      4
`define MWD_STB_LSB       5
`define MWD_STB_MSB       7
`define MWD_FIELD_MSB     5
`define MWD_ANDOR_BIT     6
`define MWD_MODE_BIT      7
`define MWD_SEL_MSB       2
`define MWD_SEL_NONE      3'h0
`define MWD_SEL_THR_BASE  3'h1
`define MWD_SEL_CNT_BASE  3'h5
`define MWD_RST_SR        4'h0
`define MWD_RST_STB       3'h0
`define MWD_RST_FIELD     6'h00
`define MWD_RST_SEL       3'h0
`define MWD_NUM_AXES      3
`endif

/* logic/mwd_pkg.sv */
// Types shared by the wakeup detector modules
package mwd_pkg;
    typedef logic signed [11:0] mwd_sample_t;
    typedef logic [12:0]        mwd_delta_t;
    typedef logic [5:0]         mwd_field_t;
    typedef enum logic [0:0] {
        MWD_CUR_VS_PREV = 1'b0,
        MWD_CUR_VS_BASE = 1'b1
    } mwd_method_t;
    typedef enum logic [0:0] {
        MWD_COMB_OR  = 1'b0,
        MWD_COMB_AND = 1'b1
    } mwd_comb_t;
endpackage : mwd_pkg

/* logic/mwd_axis_if.sv */
// Per-axis link between the detector top and one axis comparator
`timescale 1ns/100ps
interface mwd_axis_if;
    mwd_pkg::mwd_sample_t sample;
    logic                 valid;
    logic                 active;
    mwd_pkg::mwd_method_t method;
    mwd_pkg::mwd_field_t  thr;
    mwd_pkg::mwd_field_t  cnt;
    logic                 hit;
    mwd_pkg::mwd_delta_t  delta;
    modport axis (input sample, valid, active, method, thr, cnt, output hit, delta);
    modport ctrl (output sample, valid, active, method, thr, cnt, input hit, delta);
endinterface : mwd_axis_if

/* logic/mwd_axis.sv */
// One axis: delta count, threshold compare and detection counter
`timescale 1ns/100ps
module mwd_axis (
    input  wire logic clk,
    input  wire logic srst,
    mwd_axis_if.axis  ax
);
    mwd_pkg::mwd_sample_t ref_q;
    logic                 ref_ok_q;
    mwd_pkg::mwd_field_t  evt_q;
    logic                 hit_q;
    logic        [12:0]   diff_w;
    logic        [12:0]   mag_w;
    logic                 event_w;
    logic                 take_ref_w;

    // Reference is previous sample, or first sample of the sniff period
    assign diff_w     = {ax.sample[11], ax.sample} - {ref_q[11], ref_q};
    assign mag_w      = diff_w[12] ? 13'(-diff_w) : diff_w;
    assign event_w    = ax.valid && ax.active && ref_ok_q
                        && (mag_w > {7'h00, ax.thr});
    assign take_ref_w = !ref_ok_q || (ax.method == mwd_pkg::MWD_CUR_VS_PREV);
    assign ax.hit     = hit_q;
    assign ax.delta   = mag_w;

    always_ff @(posedge clk) begin
        if (srst || !ax.active) begin
            ref_q    <= '0;
            ref_ok_q <= 1'b0;
            evt_q    <= '0;
            hit_q    <= 1'b0;
        end else if (ax.valid) begin
            if (take_ref_w) begin
                ref_q <= ax.sample;
            end
            ref_ok_q <= 1'b1;
            if (event_w) begin
                // Stored count is events minus one
                if (evt_q == ax.cnt) begin
                    hit_q <= 1'b1;
                end else begin
                    evt_q <= evt_q + 6'h01;
                end
            end
        end
    end

    hit_needs_count_a : assert property (@(posedge clk) disable iff (srst)
        $rose(hit_q) |-> ($past(evt_q) == $past(ax.cnt)) && $past(event_w))
        else $error("Axis hit without reaching its detection count");

    base_held_a : assert property (@(posedge clk) disable iff (srst)
        (ax.method == mwd_pkg::MWD_CUR_VS_BASE) && ref_ok_q && ax.active
        && ($past(ax.method) == mwd_pkg::MWD_CUR_VS_BASE)
        && $past(ref_ok_q) && $past(ax.active) |-> $stable(ref_q))
        else $error("Baseline changed during sniff");
endmodule : mwd_axis

/* bench/mwd_host.sv */
// Host model: register writes, reads and the fastest sniff rate setup
`timescale 1ns/100ps
module mwd_host (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    int gap = 0;
    initial begin
        reg_addr  = 8'hff;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task automatic wr_rate(input logic [7:0] d);
        wr(8'h12, d & 8'hef);
    endtask : wr_rate
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask : rd
    task automatic rate15();
        wr(8'h10, 8'h01);
        wr(8'h15, 8'h04);
        wr(8'h16, 8'h5d);
        wr(8'h1c, 8'h00);
        wr(8'h11, 8'h10);
        wr(8'h29, 8'h30);
        wr(8'h11, 8'h30);
        wr(8'h29, 8'h01);
        wr(8'h11, 8'h60);
        wr(8'h29, 8'h72);
        wr(8'h11, 8'h70);
        wr(8'h29, 8'h02);
        wr(8'h11, 8'h0f);
        wr_rate(8'h0f);
        wr(8'h10, 8'h02);
    endtask : rate15
endmodule : mwd_host

/* bench/tb_top.sv */
// Testbench: register access and wakeup scenarios for the detector
`timescale 1ns/100ps
module tb_top;
    logic                 clk          = 1'b0;
    logic                 srst         = 1'b1;
    logic                 sniff_active = 1'b0;
    logic                 sample_valid = 1'b0;
    mwd_pkg::mwd_sample_t sample_x     = '0;
    mwd_pkg::mwd_sample_t sample_y     = '0;
    mwd_pkg::mwd_sample_t sample_z     = '0;
    logic [2:0]           axis_enable  = 3'h1;
    logic [7:0]           reg_addr;
    logic [7:0]           reg_wdata;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [7:0]           reg_rdata;
    logic [3:0]           watch_sample_rate_sel;
    logic [2:0]           standby_clock_rate_sel;
    logic                 wake_irq;
    logic [7:0]           d;
    int                   failures     = 0;
    int                   check_count  = 0;
    always #5 clk = ~clk;
    mwd_host u_mwd_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    mwd_top u_mwd_top (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sniff_active(sniff_active),
        .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y),
        .sample_z(sample_z), .axis_enable(axis_enable),
        .watch_sample_rate_sel(watch_sample_rate_sel),
        .standby_clock_rate_sel(standby_clock_rate_sel), .wake_irq(wake_irq));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rv(input logic [7:0] a, input logic [7:0] e);
        u_mwd_host.rd(a, d);
        chk("rd_data", e, d);
    endtask : rv
    task automatic sw(input mwd_pkg::mwd_sample_t x, input mwd_pkg::mwd_sample_t y,
                      input logic e);
        @(posedge clk);
        sample_valid <= 1'b1;
        sample_x     <= x;
        sample_y     <= y;
        sample_z     <= y;
        @(posedge clk);
        sample_valid <= 1'b0;
        sample_x     <= ~x;
        sample_y     <= ~y;
        sample_z     <= ~y;
        @(posedge clk);
        #1 chk("wake_irq", {7'h00, e}, {7'h00, wake_irq});
    endtask : sw
    task automatic leave();
        @(posedge clk);
        sniff_active <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("wake_irq", 8'h00, {7'h00, wake_irq});
        @(posedge clk);
        sniff_active <= 1'b1;
    endtask : leave
    task automatic z_axis_run();
        u_mwd_host.wr(8'h14, 8'h03);
        u_mwd_host.wr(8'h13, 8'h3f);
        rv(8'h13, 8'h3f);
        u_mwd_host.wr(8'h14, 8'h07);
        u_mwd_host.wr(8'h13, 8'h3d);
        rv(8'h13, 8'h3d);
        u_mwd_host.wr(8'h14, 8'h04);
        u_mwd_host.wr(8'h13, 8'h6a);
        rv(8'h13, 8'h40);
        u_mwd_host.wr(8'h14, 8'h07);
        u_mwd_host.wr(8'h13, 8'h00);
        u_mwd_host.wr(8'h14, 8'h03);
        u_mwd_host.wr(8'h13, 8'h02);
        axis_enable <= 3'h4;
        sw(12'h000, 12'h000, 1'b0);
        sw(12'h000, 12'h002, 1'b0);
        sw(12'h000, 12'h005, 1'b1);
    endtask : z_axis_run
    task automatic reset_again();
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rv(8'h12, 8'h00);
        rv(8'h14, 8'h00);
        chk("wake_irq", 8'h00, {7'h00, wake_irq});
        u_mwd_host.wr(8'h14, 8'h01);
        rv(8'h13, 8'h00);
    endtask : reset_again
    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("ERROR watchdog expected done seen timeout");
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rv(8'h12, 8'h00);
        rv(8'h13, 8'h00);
        rv(8'h14, 8'h00);
        chk("wake_irq", 8'h00, {7'h00, wake_irq});
        u_mwd_host.wr_rate(8'he5);
        rv(8'h12, 8'he5);
        chk("rate_sel", 8'h75, {1'b0, standby_clock_rate_sel, watch_sample_rate_sel});
        u_mwd_host.gap = 2;
        u_mwd_host.rate15();
        rv(8'h12, 8'h0f);
        rv(8'h13, 8'h00);
        u_mwd_host.gap = 0;
        u_mwd_host.wr(8'h14, 8'h01);
        u_mwd_host.wr(8'h13, 8'h05);
        rv(8'h13, 8'h05);
        u_mwd_host.wr(8'h14, 8'h00);
        u_mwd_host.wr(8'h13, 8'h3f);
        rv(8'h13, 8'h00);
        u_mwd_host.wr(8'h14, 8'h05);
        u_mwd_host.wr(8'h13, 8'h01);
        rv(8'h13, 8'h01);
        rv(8'h14, 8'h05);
        @(posedge clk);
        sniff_active <= 1'b1;
        sw(12'h000, 12'h000, 1'b0);
        sw(12'h00a, 12'h000, 1'b0);
        sw(12'h000, 12'h000, 1'b1);
        leave();
        u_mwd_host.wr(8'h13, 8'h00);
        sw(12'h000, 12'h000, 1'b0);
        sw(12'h005, 12'h000, 1'b0);
        sw(12'h00a, 12'h000, 1'b0);
        sw(12'h010, 12'h000, 1'b1);
        leave();
        u_mwd_host.wr(8'h13, 8'h80);
        sw(12'h000, 12'h000, 1'b0);
        sw(12'h004, 12'h000, 1'b0);
        sw(12'h008, 12'h000, 1'b1);
        leave();
        u_mwd_host.wr(8'h13, 8'h40);
        u_mwd_host.wr(8'h14, 8'h02);
        u_mwd_host.wr(8'h13, 8'h43);
        axis_enable <= 3'h3;
        sw(12'h000, 12'h000, 1'b0);
        sw(12'h00a, 12'h000, 1'b0);
        sw(12'h00a, 12'h00a, 1'b1);
        leave();
        z_axis_run();
        reset_again();
        end_sim();
    end
endmodule : tb_top
